// ==== pkg/scs_pkg.sv ====
package scs_pkg;

    // primary opcodes
    localparam logic [5:0] OP_REGFMT   = 6'h00;
    localparam logic [5:0] OP_LT_IMM   = 6'h0a;
    localparam logic [5:0] OP_LTU_IMM  = 6'h0b;
    localparam logic [5:0] OP_ST_HALF  = 6'h29;
    localparam logic [5:0] OP_ST_DW_R  = 6'h2d;
    // function codes under the register format opcode
    localparam logic [5:0] FN_SHL_IMM  = 6'h00;
    localparam logic [5:0] FN_ASR_IMM  = 6'h03;
    localparam logic [5:0] FN_SHL_VAR  = 6'h04;
    localparam logic [5:0] FN_LT_REG   = 6'h2a;
    localparam logic [5:0] FN_LTU_REG  = 6'h2b;

    // instruction field positions
    localparam int OPC_LSB  = 26;
    localparam int SRC1_LSB = 21;
    localparam int SRC2_LSB = 16;
    localparam int RD_LSB   = 11;
    localparam int AMT_LSB  = 6;

    // transfer size codes sent to memory
    localparam logic [2:0] SIZE_HALF   = 3'h1;
    localparam logic [2:0] SIZE_DWORD  = 3'h7;

    // reset values
    localparam logic [63:0] RST_DATA   = 64'h0000_0000_0000_0000;
    localparam logic [4:0]  RST_REG    = 5'h00;

    typedef enum logic [1:0] {
        SCS_EXC_NONE     = 2'b00,
        SCS_EXC_RESERVED = 2'b01,
        SCS_EXC_ADDRESS  = 2'b10
    } scs_exc_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] instr;
        logic [63:0] src_a;   // first_source_field / base value
        logic [63:0] src_b;   // target_source_field value
        logic        mode64;
        logic        user_or_super;
        logic        cpu_byte_order;
        logic        memory_byte_order;
    } scs_req_t;

    typedef struct packed {
        logic        wr_en;
        logic [4:0]  wr_reg;
        logic [63:0] wr_data;
    } scs_wb_t;

    typedef struct packed {
        logic        st_en;
        logic [63:0] virtual_addr;
        logic [2:0]  phys_offset;
        logic [2:0]  transfer_size_code;
        logic [63:0] data;
        logic [7:0]  byte_en;
    } scs_mem_t;

endpackage

// ==== verilog/scs_shifter.sv ====
`timescale 1ns/1ps
module scs_shifter (
    // operand and control
    input  wire logic [63:0] value,
    input  wire logic [4:0]  amount,
    input  wire logic        arith_right,
    input  wire logic        mode64,
    // result
    output logic [63:0]      result
);
    logic [31:0] word_in;
    logic [31:0] word_left;
    logic [31:0] word_right;
    logic [31:0] word_out;

    assign word_in    = value[31:0];
    assign word_left  = word_in << amount;
    assign word_right = 32'($signed(word_in) >>> amount);
    assign word_out   = arith_right ? word_right : word_left;
    // in 64-bit mode sign-extend from bit 31 even for zero amount; otherwise zero-extend
    assign result = mode64 ? {{32{word_out[31]}}, word_out}
                           : {32'h0000_0000, word_out};
endmodule

// ==== verilog/scs_compare.sv ====
`timescale 1ns/1ps
module scs_compare (
    // operands
    input  wire logic [63:0] lhs,
    input  wire logic [63:0] rhs,
    input  wire logic        is_unsigned,
    // verdict
    output logic             less
);
    logic [64:0] diff;
    logic        ovf;
    logic        s_less;

    // 65-bit difference; borrow bit gives the unsigned answer
    assign diff   = {1'b0, lhs} - {1'b0, rhs};
    // sign of difference corrected for overflow, so no trap is needed
    assign ovf    = (lhs[63] ^ rhs[63]) & (lhs[63] ^ diff[63]);
    assign s_less = diff[63] ^ ovf;
    assign less   = is_unsigned ? diff[64] : s_less;
endmodule

// ==== verilog/scs_unit.sv ====
`timescale 1ns/1ps
module scs_unit (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            rstn,
    // request from decode
    input  wire scs_pkg::scs_req_t req,
    // results, one cycle after the request
    output scs_pkg::scs_wb_t     wb,
    output scs_pkg::scs_mem_t    mem,
    output scs_pkg::scs_exc_t    exc,
    output logic                 illegal
);
    ////////////////////////////////////////////////////////////////////////
    logic [5:0]  opc;
    logic [5:0]  fn;
    logic [4:0]  src1_f;
    logic [4:0]  src2_f;
    logic [4:0]  rd_f;
    logic [4:0]  amt_f;
    logic [63:0] imm_sx;
    logic [63:0] eff_addr;

    assign opc    = req.instr[scs_pkg::OPC_LSB +: 6];
    assign fn     = req.instr[5:0];
    assign src1_f = req.instr[scs_pkg::SRC1_LSB +: 5];
    assign src2_f = req.instr[scs_pkg::SRC2_LSB +: 5];
    assign rd_f   = req.instr[scs_pkg::RD_LSB +: 5];
    assign amt_f  = req.instr[scs_pkg::AMT_LSB +: 5];
    assign imm_sx = {{48{req.instr[15]}}, req.instr[15:0]};
    assign eff_addr = req.src_a + imm_sx;

    ////////////////////////////////////////////////////////////////////////
    // decode
    logic is_rf;
    logic dec_shl_i;
    logic dec_shl_v;
    logic dec_asr_i;
    logic dec_lt_r;
    logic dec_ltu_r;
    logic dec_lt_i;
    logic dec_ltu_i;
    logic dec_sth;
    logic dec_stdr;
    logic any_shift;
    logic any_cmp;

    assign is_rf     = req.valid && (opc == scs_pkg::OP_REGFMT);
    assign dec_shl_i = is_rf && fn == scs_pkg::FN_SHL_IMM
                       && src1_f == 5'h00;
    assign dec_asr_i = is_rf && fn == scs_pkg::FN_ASR_IMM
                       && src1_f == 5'h00;
    assign dec_shl_v = is_rf && fn == scs_pkg::FN_SHL_VAR;
    assign dec_lt_r  = is_rf && fn == scs_pkg::FN_LT_REG;
    assign dec_ltu_r = is_rf && fn == scs_pkg::FN_LTU_REG;
    assign dec_lt_i  = req.valid && opc == scs_pkg::OP_LT_IMM;
    assign dec_ltu_i = req.valid && opc == scs_pkg::OP_LTU_IMM;
    assign dec_sth   = req.valid && opc == scs_pkg::OP_ST_HALF;
    assign dec_stdr  = req.valid && opc == scs_pkg::OP_ST_DW_R;
    assign any_shift = dec_shl_i || dec_shl_v || dec_asr_i;
    assign any_cmp   = dec_lt_r || dec_ltu_r || dec_lt_i || dec_ltu_i;

    ////////////////////////////////////////////////////////////////////////
    // shifts
    logic [4:0]  shf_amt;
    logic [63:0] shf_res;

    // variable form takes only the low five bits of the first source
    assign shf_amt = dec_shl_v ? req.src_a[4:0] : amt_f;

    // no operand check: sign-extension happens on output only
    scs_shifter u_shift (
        .value       (req.src_b),
        .amount      (shf_amt),
        .arith_right (dec_asr_i),
        .mode64      (req.mode64),
        .result      (shf_res)
    );

    ////////////////////////////////////////////////////////////////////////
    // compares
    logic [63:0] cmp_rhs;
    logic        cmp_uns;
    logic        cmp_less;

    // both immediate forms sign-extend, even the unsigned one
    assign cmp_rhs = (dec_lt_i || dec_ltu_i) ? imm_sx : req.src_b;
    assign cmp_uns = dec_ltu_r || dec_ltu_i;

    // overflow-corrected; no overflow exception path exists
    scs_compare u_cmp (
        .lhs         (req.src_a),
        .rhs         (cmp_rhs),
        .is_unsigned (cmp_uns),
        .less        (cmp_less)
    );

    ////////////////////////////////////////////////////////////////////////
    // store-doubleword-right merge
    logic [2:0]  byte_idx;
    logic [2:0]  dwr_size;
    logic [2:0]  dwr_off;
    logic [63:0] dwr_data;
    logic [7:0]  dwr_be;
    logic        dwr_resv;

    assign byte_idx = eff_addr[2:0] ^ {3{req.cpu_byte_order}};
    assign dwr_size = 3'h7 - eff_addr[2:0];
    assign dwr_off  = req.memory_byte_order ? 3'h0 : eff_addr[2:0];
    // register low bytes land from byte n upward; lower bytes kept
    assign dwr_data = req.src_b << {byte_idx, 3'b000};
    assign dwr_be   = 8'hff << byte_idx;
    assign dwr_resv = !req.mode64 && req.user_or_super;

    ////////////////////////////////////////////////////////////////////////
    // store-halfword
    logic        half_misal;
    logic [7:0]  half_be;
    logic [63:0] half_data;

    assign half_misal = eff_addr[0];
    assign half_be    = 8'h03 << {eff_addr[2:1], 1'b0};
    assign half_data  = {48'h0000_0000_0000, req.src_b[15:0]}
                        << {eff_addr[2:1], 4'b0000};

    ////////////////////////////////////////////////////////////////////////
    // next values
    scs_pkg::scs_wb_t  next_wb;
    scs_pkg::scs_mem_t next_mem;
    scs_pkg::scs_exc_t next_exc;
    logic              next_illegal;
    logic              st_ok_dwr;
    logic              st_ok_half;
    logic [4:0]        cmp_dst;

    assign st_ok_dwr  = dec_stdr && !dwr_resv;
    assign st_ok_half = dec_sth && !half_misal;
    // register compares write the destination field, immediates the target
    assign cmp_dst   = (dec_lt_r || dec_ltu_r) ? rd_f : src2_f;

    assign next_wb.wr_en   = any_shift || any_cmp;
    assign next_wb.wr_reg  = any_shift ? rd_f :
                             any_cmp   ? cmp_dst : scs_pkg::RST_REG;
    assign next_wb.wr_data = any_shift ? shf_res :
                             {63'h0, cmp_less};

    assign next_mem.st_en        = st_ok_dwr || st_ok_half;
    assign next_mem.virtual_addr = eff_addr;
    assign next_mem.phys_offset  = dec_stdr ? dwr_off :
                                   (req.memory_byte_order ? 3'h0
                                                          : eff_addr[2:0]);
    assign next_mem.transfer_size_code = dec_stdr ? dwr_size
                                                  : scs_pkg::SIZE_HALF;
    assign next_mem.data    = dec_stdr ? dwr_data : half_data;
    assign next_mem.byte_en = st_ok_dwr  ? dwr_be  :
                              st_ok_half ? half_be : 8'h00;

    assign next_exc = (dec_stdr && dwr_resv) ? scs_pkg::SCS_EXC_RESERVED :
                      (dec_sth && half_misal) ? scs_pkg::SCS_EXC_ADDRESS :
                                                scs_pkg::SCS_EXC_NONE;

    // valid instruction this unit does not own
    assign next_illegal = req.valid && !any_shift && !any_cmp
                          && !dec_sth && !dec_stdr;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wb      <= '0;
            mem     <= '0;
            exc     <= scs_pkg::SCS_EXC_NONE;
            illegal <= 1'b0;
        end else begin
            wb      <= next_wb;
            mem     <= next_mem;
            exc     <= next_exc;
            illegal <= next_illegal;
        end
    end
endmodule

// ==== verification/scs_unit_chk.sv ====
`timescale 1ns/1ps
module scs_unit_chk (
    // clock and reset
    input wire logic              clk,
    input wire logic              rstn,
    // watched ports
    input wire scs_pkg::scs_req_t req,
    input wire scs_pkg::scs_wb_t  wb,
    input wire scs_pkg::scs_mem_t mem,
    input wire scs_pkg::scs_exc_t exc,
    input wire logic              illegal
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire [5:0]  fn   = req.instr[5:0];
    wire [5:0]  op   = req.instr[31:26];
    wire        rf   = req.valid && op == scs_pkg::OP_REGFMT;
    wire        rs0  = req.instr[25:21] == 5'h00;
    wire [63:0] imm  = {{48{req.instr[15]}}, req.instr[15:0]};
    wire [63:0] addr = req.src_a + imm;
    wire [31:0] li   = req.src_b[31:0] << req.instr[10:6];
    wire [31:0] lv   = req.src_b[31:0] << req.src_a[4:0];
    wire [31:0] ra   = $signed(req.src_b[31:0]) >>> req.instr[10:6];
    wire [63:0] e_li = {{32{li[31]}}, li};
    wire [63:0] e_lv = {{32{lv[31]}}, lv};
    wire [63:0] e_ra = {{32{ra[31]}}, ra};
    wire        lt_s = $signed(req.src_a) < $signed(req.src_b);
    wire        lt_i = $signed(req.src_a) < $signed(imm);
    wire        lt_u = req.src_a < req.src_b;
    wire        lt_v = req.src_a < imm;
    wire        stdr = req.valid && op == scs_pkg::OP_ST_DW_R;
    wire        sth  = req.valid && op == scs_pkg::OP_ST_HALF;
    wire        shli = rf && fn == scs_pkg::FN_SHL_IMM && rs0;
    shl_imm_sext_a: assert property (shli && req.mode64
        |=> wb.wr_en && wb.wr_data == $past(e_li))
        else $error("left shift imm");
    shl_var_sext_a: assert property (
        rf && fn == scs_pkg::FN_SHL_VAR && req.mode64
        |=> wb.wr_data == $past(e_lv) && exc == 2'h0)
        else $error("left shift var");
    asr_imm_sext_a: assert property (
        rf && fn == scs_pkg::FN_ASR_IMM && rs0 && req.mode64
        |=> wb.wr_data == $past(e_ra)) else $error("right shift");
    lt_reg_flag_a: assert property (rf && fn == scs_pkg::FN_LT_REG
        |=> !illegal && wb.wr_data == {63'h0, $past(lt_s)} && exc == 2'h0)
        else $error("signed reg compare");
    lt_imm_flag_a: assert property (req.valid && op == scs_pkg::OP_LT_IMM
        |=> wb.wr_data == {63'h0, $past(lt_i)})
        else $error("signed imm compare");
    ltu_reg_flag_a: assert property (rf && fn == scs_pkg::FN_LTU_REG
        |=> wb.wr_data == {63'h0, $past(lt_u)} && exc == 2'h0)
        else $error("unsigned reg compare");
    ltu_imm_flag_a: assert property (req.valid && op == scs_pkg::OP_LTU_IMM
        |=> wb.wr_data == {63'h0, $past(lt_v)})
        else $error("unsigned imm compare");
    shl_word_zero_a: assert property (shli && !req.mode64
        |=> wb.wr_data == {32'h0, $past(li)}) else $error("left shift 32");
    dwr_size_a: assert property (
        stdr && req.mode64 && !req.memory_byte_order
        |=> mem.st_en && mem.transfer_size_code == 3'h7 - $past(addr[2:0])
        && mem.phys_offset == $past(addr[2:0])) else $error("dw right");
    dwr_resv_a: assert property (stdr && !req.mode64
        && req.user_or_super |=> exc == 2'h1 && !mem.st_en)
        else $error("resv");
    half_align_a: assert property (sth && addr[0]
        |=> exc == 2'h2 && !mem.st_en) else $error("half odd");
    half_addr_a: assert property (sth && !addr[0] |=> mem.st_en
        && mem.virtual_addr == $past(addr)) else $error("half addr");
endmodule
bind scs_unit scs_unit_chk i_scs_unit_chk (.clk(clk), .rstn(rstn),
    .req(req), .wb(wb), .mem(mem), .exc(exc), .illegal(illegal));

// ==== verification/scs_mem_model.sv ====
`timescale 1ns/1ps
module scs_mem_model #(
    parameter logic [63:0] BG = 64'h5050_5050_5050_5050
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // store from the unit
    input  wire scs_pkg::scs_mem_t mem,
    // merged doubleword
    output logic [63:0]            word
);
    // each store lands on a fresh background so lanes are judged alone
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            word <= BG;
        end else if (mem.st_en) begin
            for (int i = 0; i < 8; i++) begin
                word[8*i +: 8] <= mem.byte_en[i] ? mem.data[8*i +: 8]
                                                 : BG[8*i +: 8];
            end
        end
    end
endmodule

// ==== verification/scs_unit_bench.sv ====
`timescale 1ns/1ps
module scs_unit_bench;
    localparam logic [63:0] BG = 64'h5050_5050_5050_5050;
    localparam logic [63:0] B  = 64'h8877_6655_4433_2211;
    logic              clk;
    logic              rstn;
    scs_pkg::scs_req_t req;
    scs_pkg::scs_wb_t  wb;
    scs_pkg::scs_mem_t mem;
    scs_pkg::scs_exc_t exc;
    logic              illegal;
    logic [63:0]       word;
    int                error_cnt;
    int                n_checks;
    scs_unit i_scs_unit (.clk(clk), .rstn(rstn), .req(req), .wb(wb),
        .mem(mem), .exc(exc), .illegal(illegal));
    scs_mem_model #(.BG(BG)) i_scs_mem_model (.clk(clk), .rstn(rstn),
        .mem(mem), .word(word));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(string s, logic [63:0] e, logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    function automatic logic [31:0] rfm(logic [5:0] f, logic [4:0] s,
                                        logic [4:0] amt);
        return {6'h00, s, 5'h02, 5'h03, amt, f};
    endfunction
    function automatic logic [31:0] im(logic [5:0] op, logic [15:0] v);
        return {op, 5'h01, 5'h02, v};
    endfunction
    // md packs mode64, user_or_super, cpu order, memory order
    task automatic run(logic [31:0] ins, logic [63:0] a, logic [63:0] b,
                       logic [3:0] md);
        @(posedge clk);
        req <= {1'b1, ins, a, b, md};
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
    endtask
    task automatic t_shift();
        logic [31:0] t;
        for (int s = 0; s < 32; s += 31) begin
            t = B[31:0] << s;
            run(rfm(scs_pkg::FN_SHL_IMM, 5'h00, s[4:0]), 0, B, 4'h8);
            chk("shl_imm", {{32{t[31]}}, t}, wb.wr_data);
            chk("shl_imm_wb", 64'h23, {wb.wr_en, wb.wr_reg});
        end
        run(rfm(scs_pkg::FN_SHL_IMM, 5'h00, 5'h01), 0, B, 4'h0);
        chk("shl_imm32", 64'h8866_4422, wb.wr_data);
        run(rfm(scs_pkg::FN_SHL_VAR, 5'h01, 5'h00), -28, B, 4'h8);
        chk("shl_var", 64'h4332_2110, wb.wr_data);
        run(rfm(scs_pkg::FN_ASR_IMM, 5'h00, 5'h04), 0, -(2**31), 4'h8);
        chk("asr_imm", 64'hffff_ffff_f800_0000, wb.wr_data);
        run(rfm(scs_pkg::FN_SHL_IMM, 5'h01, 5'h01), 0, B, 4'h8);
        chk("illegal", 1, illegal);
    endtask
    task automatic cmp(logic [31:0] ins, logic [63:0] a, logic [63:0] b,
                       logic e);
        run(ins, a, b, 4'h8);
        chk("cmp", e, wb.wr_data);
        chk("cmp_exc", 0, exc);
    endtask
    task automatic t_cmp();
        logic [63:0] mx;
        mx = 64'h7fff_ffff_ffff_ffff;
        cmp(rfm(scs_pkg::FN_LT_REG, 1, 0), mx, ~mx, 0);
        cmp(rfm(scs_pkg::FN_LT_REG, 1, 0), ~mx, mx, 1);
        cmp(rfm(scs_pkg::FN_LTU_REG, 1, 0), mx, ~mx, 1);
        cmp(im(scs_pkg::OP_LT_IMM, 16'hffff), -2, 0, 1);
        chk("cmp_dst", 2, wb.wr_reg);
        cmp(im(scs_pkg::OP_LT_IMM, 16'h8000), 0, 0, 0);
        cmp(im(scs_pkg::OP_LTU_IMM, 16'hffff), 64'h1_0000, 0, 1);
    endtask
    task automatic t_stdr();
        for (int n = 0; n < 8; n++) begin
            run(im(scs_pkg::OP_ST_DW_R, 16'h0), 64'h1000 + n, B, 4'h8);
            chk("dwr_size", 7 - n, mem.transfer_size_code);
            chk("dwr_off", n, mem.phys_offset);
            chk("dwr_en", 8'(8'hff << n), mem.byte_en);
            chk("dwr_data", B << 8*n, mem.data);
            @(posedge clk);
            #1;
            chk("dwr_mem", (B << 8*n) | (BG & ~('1 << 8*n)), word);
        end
        run(im(scs_pkg::OP_ST_DW_R, 16'h0), 64'h1000, B, 4'ha);
        chk("dwr_be", 8'h80, mem.byte_en);
        run(im(scs_pkg::OP_ST_DW_R, 16'h0), 64'h1003, B, 4'h9);
        chk("dwr_bem", 0, mem.phys_offset);
        run(im(scs_pkg::OP_ST_DW_R, 16'h0), 64'h1003, B, 4'h4);
        chk("dwr_resv", 1, {mem.st_en, exc});
        run(im(scs_pkg::OP_ST_DW_R, 16'h0), 64'h1003, B, 4'h0);
        chk("dwr_kern", 4, {mem.st_en, exc});
    endtask
    task automatic t_sthalf();
        run(im(scs_pkg::OP_ST_HALF, 16'hfffe), 64'h2000, B, 4'h8);
        chk("half_addr", 64'h1ffe, mem.virtual_addr);
        chk("half_data", {16'h2211, 48'h0}, mem.data);
        chk("half_en", 8'hc0, mem.byte_en);
        chk("half_size", scs_pkg::SIZE_HALF, mem.transfer_size_code);
        run(im(scs_pkg::OP_ST_HALF, 16'h0001), 64'h2000, B, 4'h8);
        chk("half_odd", 2, {mem.st_en, exc});
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        error_cnt = 0;
        n_checks = 0;
        rstn = 1'b0;
        req = '0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        t_shift();
        t_cmp();
        t_stdr();
        t_sthalf();
        stop_test();
    end
    // the whole run needs well under 200 cycles
    initial begin
        repeat (2000) @(posedge clk);
        error_cnt++;
        stop_test();
    end
endmodule
